/* src/ssi_out_defines.vh */
// shared constants for the serial angle output stage
`ifndef SSI_OUT_DEFINES_VH
`define SSI_OUT_DEFINES_VH
// system clock rate in kHz
`define SYS_CLK_KHZ 25000
// angle word width and number of positions
`define ANGLE_BITS 9
`define ANGLE_POSITIONS 512
// monoflop nominal time and tolerance in microseconds
`define MONO_TIME_US 25
`define MONO_TOL_US 10
// monoflop count in system clocks
`define MONO_CYCLES ((`MONO_TIME_US * `SYS_CLK_KHZ) / 1000)
`define MONO_CNT_BITS 10
// serial clock limit and safety gap
`define SER_CLK_MAX_KHZ 1000
`define SAFETY_GAP_NS 50
// loop delay figures
`define ENC_DELAY_NS 300
`define CABLE_DELAY_PS_PER_M 6500
`define RCV_DELAY_NS 150
// fifo shape
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

/* src/pin_sync.v */
// two-stage synchroniser for an outside level
`default_nettype none
module pin_sync (
  input wire clk,
  input wire rst_n,
  input wire d,
  output reg q
);
  reg meta;
  // first stage feeds second only, idle high
  always @(posedge clk) begin
    if (!rst_n) begin
      meta <= 1'b1;
      q <= 1'b1;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // pin_sync
`default_nettype wire

/* src/angle_fifo.v */
// small fifo for sampled angle words
`default_nettype none
module angle_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire full;
  wire empty;
  // pointer compare with wrap bit
  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];
  // write side
  always @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  // pointer update
  always @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // angle_fifo
`default_nettype wire

/* src/ssi_angle_out.v */
// synchronous serial output stage for a 9-bit absolute angle
`default_nettype none
`include "ssi_out_defines.vh"
module ssi_angle_out (
  input wire SYS_CLK,
  input wire RST_N,
  input wire [8:0] ANGLE,       // raw angle from sensor, clockwise direction set by CW_IS_UP
  input wire ANGLE_VALID,       // new sample strobe
  output wire ANGLE_READY,      // fifo can take a sample
  input wire CW_IS_UP,          // sensor orientation: 1 means raw rises clockwise
  input wire SER_CLK,           // serial clock from receiver
  output reg SER_DATA,          // serial data to receiver
  output reg BUSY               // frame in progress
);
  // ************************************************************
  // states
  // ************************************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SHIFT = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;
  localparam integer MONO_FULL = `MONO_CYCLES;
  localparam [9:0] MONO_LOAD = MONO_FULL[9:0];

  // ************************************************************
  // helpers
  // ************************************************************
  // orientation correction so value rises clockwise
  function [8:0] cw_value;
    input [8:0] raw;
    input up;
    begin
      if (up) begin
        cw_value = raw;
      end else begin
        cw_value = 9'h000 - raw;
      end
    end
  endfunction

  wire sclk_s;
  wire fifo_valid;
  wire [8:0] fifo_data;
  reg fifo_take;
  reg sclk_d;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [8:0] shreg;
  reg [8:0] latest;
  reg [3:0] bit_cnt;
  reg [9:0] mono;
  reg first_rise;
  wire fall;
  wire rise;

  // ************************************************************
  // input path
  // ************************************************************
  pin_sync u_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .d(SER_CLK),
    .q(sclk_s)
  );

  angle_fifo #(
    .WIDTH(`ANGLE_BITS),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .in_valid(ANGLE_VALID),
    .in_ready(ANGLE_READY),
    .in_data(ANGLE),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_data)
  );

  // drain fifo continuously, newest sample kept
  always @* begin
    fifo_take = fifo_valid;
  end

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      latest <= 9'h000;
    end else if (fifo_valid) begin
      latest <= cw_value(fifo_data, CW_IS_UP);
    end
  end

  // edge detect on synchronised clock
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sclk_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
    end
  end
  assign fall = sclk_d && !sclk_s;
  assign rise = !sclk_d && sclk_s;

  // ************************************************************
  // frame control
  // ************************************************************
  // next state
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (fall) begin
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (mono == 10'h000) begin
          next_state = ST_IDLE;
        end else if (rise && bit_cnt == 4'h0 && !first_rise) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (mono == 10'h000) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state register
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      mono <= 10'h000;
    end else if ((state == ST_IDLE && fall) || (state != ST_IDLE && (fall || rise))) begin
      mono <= MONO_LOAD;
    end else if (mono != 10'h000) begin
      mono <= mono - 10'h001;
    end
  end

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      shreg <= 9'h000;
      bit_cnt <= 4'h0;
      first_rise <= 1'b0;
    end else if (state == ST_IDLE && fall) begin
      shreg <= latest;
      bit_cnt <= 4'h9;
      first_rise <= 1'b1;
    end else if (state == ST_SHIFT && rise) begin
      if (first_rise) begin
        first_rise <= 1'b0;
      end
      if (bit_cnt != 4'h0) begin
        shreg <= {shreg[7:0], 1'b0};
        bit_cnt <= bit_cnt - 4'h1;
      end
    end
  end

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      SER_DATA <= 1'b1;
    end else if (next_state == ST_IDLE) begin
      SER_DATA <= 1'b1;
    end else if (state == ST_SHIFT && rise) begin
      if (bit_cnt != 4'h0) begin
        SER_DATA <= shreg[8];
      end else begin
        SER_DATA <= 1'b0;
      end
    end else if (state == ST_IDLE && fall) begin
      SER_DATA <= 1'b1;
    end
  end

  // busy flag
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      BUSY <= 1'b0;
    end else begin
      BUSY <= (next_state != ST_IDLE);
    end
  end
endmodule // ssi_angle_out
`default_nettype wire

/* tb/ssi_angle_out_assertions.sv */
// checker for the serial angle output stage
`default_nettype none
module ssi_angle_out_checker (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic SER_CLK,
  input wire logic SER_DATA,
  input wire logic BUSY
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev;
  logic [9:0] cnt;
  // ***
  // cycles since the link clock moved
  // ***
  always @(posedge SYS_CLK) begin
    prev <= SER_CLK;
    if (!RST_N || SER_CLK != prev) cnt <= 10'h000;
    else if (cnt != 10'h3FF) cnt <= cnt + 10'h001;
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  a_reset_idle: assert property ($rose(RST_N) |-> SER_DATA && !BUSY)
    else $error("outputs not idle after reset");
  a_idle_high: assert property (!BUSY |-> SER_DATA)
    else $error("data low outside a frame");
  a_frame_start: assert property ($fell(SER_CLK) && !BUSY |-> ##[1:6] BUSY)
    else $error("fall did not start a frame");
  a_busy_hold: assert property (BUSY && cnt < 10'h172 |=> BUSY)
    else $error("frame ended too early");
  a_mono_span: assert property ($fell(BUSY) |-> cnt >= 10'h177 && cnt <= 10'h36B)
    else $error("monoflop time out of range");
  a_mono_end: assert property (cnt > 10'h36F |-> !BUSY)
    else $error("frame did not end");
  a_shift_edge: assert property ($changed(SER_DATA) && BUSY |-> cnt <= 10'h006)
    else $error("data moved away from a clock edge");
endmodule // ssi_angle_out_checker
bind ssi_angle_out ssi_angle_out_checker u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .SER_CLK(SER_CLK), .SER_DATA(SER_DATA), .BUSY(BUSY));
`default_nettype wire

/* tb/ssi_rx_model.sv */
// receiving controller model that clocks frames out
`default_nettype none
module ssi_rx_model (
  output logic ser_clk,
  input wire logic ser_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial ser_clk = 1'b1;
  task automatic read_frame(input int half, output logic [8:0] w, output logic stop);
    int i;
    #26000;
    ser_clk = 1'b0;
    #half;
    for (i = 0; i < 9; i++) begin
      ser_clk = 1'b1;
      #half;
      ser_clk = 1'b0;
      #half;
      w[8 - i] = ser_data;
    end
    ser_clk = 1'b1;
    #400;
    stop = ser_data;
  endtask
endmodule // ssi_rx_model
`default_nettype wire

/* tb/test_ssi_angle_out.sv */
// self-checking bench for the serial angle output stage
`default_nettype none
module test_ssi_angle_out;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_n, angle_valid, cw_is_up, stop;
  logic [8:0] angle, word;
  wire ser_clk, ser_data, busy, angle_ready;
  int bad_count, n_compared;
  ssi_angle_out DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .ANGLE(angle),
    .ANGLE_VALID(angle_valid), .ANGLE_READY(angle_ready), .CW_IS_UP(cw_is_up),
    .SER_CLK(ser_clk), .SER_DATA(ser_data), .BUSY(busy));
  ssi_rx_model u_rx (.ser_clk(ser_clk), .ser_data(ser_data));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic send_angle(input logic [8:0] a, input logic up);
    @(negedge sys_clk);
    angle = a;
    cw_is_up = up;
    angle_valid = 1'b1;
    check("ready", {8'h00, angle_ready}, 9'h001);
    @(negedge sys_clk);
    angle_valid = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic frame(input logic [8:0] exp, input int half);
    u_rx.read_frame(half, word, stop);
    check("word", word, exp);
    check("stop", {8'h00, stop}, 9'h000);
  endtask
  task automatic test_binary();
    logic [8:0] v[5] = '{9'h000, 9'h1FF, 9'h155, 9'h0AA, 9'h100};
    foreach (v[i]) begin
      send_angle(v[i], 1'b1);
      frame(v[i], 160);
    end
  endtask
  task automatic test_code_sense();
    logic [8:0] v[3] = '{9'h001, 9'h000, 9'h1FF};
    foreach (v[i]) begin
      send_angle(v[i], 1'b0);
      frame(9'h000 - v[i], 520);
    end
  endtask
  task automatic test_freeze();
    send_angle(9'h0F0, 1'b1);
    fork
      frame(9'h0F0, 160);
      begin
        #27000;
        send_angle(9'h00F, 1'b1);
      end
    join
  endtask
  task automatic test_monoflop();
    send_angle(9'h0C3, 1'b1);
    frame(9'h0C3, 160);
    repeat (360) @(negedge sys_clk);
    check("busy", {8'h00, busy}, 9'h001);
    repeat (500) @(negedge sys_clk);
    check("end", {7'h00, ser_data, busy}, 9'h002);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog well beyond ten frames
  initial begin
    #1000000;
    bad_count++;
    complete_run();
  end
  initial begin
    rst_n = 1'b0;
    angle = 9'h000;
    angle_valid = 1'b0;
    cw_is_up = 1'b1;
    bad_count = 0;
    n_compared = 0;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    check("idle", {7'h00, ser_data, busy}, 9'h002);
    test_binary();
    test_code_sense();
    test_freeze();
    test_monoflop();
    complete_run();
  end
endmodule // test_ssi_angle_out
`default_nettype wire
